/* File: rtl/clkss_pkg.sv */
// constants shared by the clock source select and start-up timer
// assumes one system clock; oscillator edges arrive as one-cycle ticks
package clkss_pkg;
  // watchdog oscillator rate and the two real-time reset delays
  localparam int unsigned WDT_OSC_HZ    = 128_000;
  localparam int unsigned RST_SHORT_US  = 4_000;
  localparam int unsigned RST_LONG_US   = 64_000;
  localparam int unsigned WDT_SHORT_CYC = RST_SHORT_US * (WDT_OSC_HZ / 1000) / 1000;
  localparam int unsigned WDT_LONG_CYC  = RST_LONG_US * (WDT_OSC_HZ / 1000) / 1000;

  // source-cycle start-up counts
  localparam int unsigned CNT_W         = 15;
  localparam int unsigned XTAL_SHORT    = 258;
  localparam int unsigned XTAL_MID      = 1024;
  localparam int unsigned XTAL_LONG     = 16384;
  localparam int unsigned GEN_START     = 6;
  localparam int unsigned RST_EXTRA     = 14;
  typedef logic [CNT_W-1:0] clkss_cnt_t;

  // clock select codes, programmed bits are zero
  localparam logic [3:0] SEL_EXT        = 4'h0;
  localparam logic [3:0] SEL_RC         = 4'h2;
  localparam logic [3:0] SEL_WDT        = 4'h4;
  localparam logic [3:0] SEL_LF         = 4'h6;
  localparam int unsigned SEL_XTAL_BIT  = 3;

  // fuse register fields and shipped image
  localparam int unsigned FUSE_W        = 7;
  localparam int unsigned SEL_LSB       = 0;
  localparam int unsigned STARTUP_LSB   = 4;
  localparam int unsigned DIV8_BIT      = 6;
  localparam logic [FUSE_W-1:0] FUSE_RST = 7'h22;

  // sleep modes as written to the power control register
  typedef enum logic [1:0] {SLP_IDLE, SLP_ADC_NR, SLP_PWR_DOWN, SLP_PWR_SAVE} clkss_sleep_e;

  // register map
  localparam int unsigned ADDR_W        = 12;
  localparam logic [11:0] REG_FUSE      = 12'h000;
  localparam logic [11:0] REG_PWR       = 12'h004;
  localparam logic [11:0] REG_STAT      = 12'h008;
  localparam int unsigned PWR_MODE_LSB  = 0;
  localparam int unsigned PWR_ENTER_BIT = 2;
  localparam int unsigned STAT_ACT_LSB  = 0;
  localparam int unsigned STAT_ST_LSB   = 8;
  localparam int unsigned STAT_RUN_BIT  = 12;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  localparam int unsigned DIV_W         = 3;
endpackage

/* File: rtl/clkss_startup_cnt.sv */
// start-up cycle counter: source cycles and watchdog cycles in parallel
// assumes ticks are one-cycle pulses synchronous to clk_sys_i
`timescale 1ns/10ps
module clkss_startup_cnt (
  input wire logic       clk_sys_i,
  input wire logic       resetn_i,
  clkss_startup_if.cnt   st
);
  clkss_pkg::clkss_cnt_t src_q;
  clkss_pkg::clkss_cnt_t wdt_q;
  logic                  done_q;
  wire logic             src_zero = (src_q == '0);
  wire logic             wdt_zero = (wdt_q == '0);

  assign st.done = done_q;

  // both counts load on start; done only once both have drained
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      src_q  <= '0;
      wdt_q  <= '0;
      done_q <= 1'b0;
    end else if (st.start) begin
      src_q  <= st.src_cycles;
      wdt_q  <= st.wdt_cycles;
      done_q <= 1'b0;
    end else begin
      if (st.src_tick && !src_zero) src_q <= src_q - 1'b1;
      if (st.wdt_tick && !wdt_zero) wdt_q <= wdt_q - 1'b1;
      done_q <= src_zero && wdt_zero;
    end
  end

  property p_src_step;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (!st.start && st.src_tick && !src_zero) |=> (src_q == $past(src_q) - 1'b1);
  endproperty
  a_src_step: assert property (p_src_step) else $error("source count did not step");

  property p_done_drained;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    done_q |-> (src_zero && wdt_zero);
  endproperty
  a_done_drained: assert property (p_done_drained) else $error("done with counts left");
endmodule

/* File: rtl/clkss_startup_if.sv */
// signals between the start-up sequencer and its cycle counter
// assumes both ends sit on clk_sys_i
`timescale 1ns/10ps
interface clkss_startup_if;
  logic                 start;
  clkss_pkg::clkss_cnt_t src_cycles;
  clkss_pkg::clkss_cnt_t wdt_cycles;
  logic                 src_tick;
  logic                 wdt_tick;
  logic                 done;
  modport ctrl (output start, output src_cycles, output wdt_cycles, output src_tick, output wdt_tick,
                input done);
  modport cnt  (input start, input src_cycles, input wdt_cycles, input src_tick, input wdt_tick,
                output done);
endinterface

/* File: rtl/clkss_top.sv */
// clock source select, start-up timing and domain gating, AXI4-Lite registers
// assumes oscillator edges arrive as one-cycle ticks on clk_sys_i (200 MHz)
`timescale 1ns/10ps
module clkss_top #(
  parameter int unsigned XTAL_LONG_CYC = clkss_pkg::XTAL_LONG,
  parameter int unsigned WDT_LONG_CYC  = clkss_pkg::WDT_LONG_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic        ext_clk_tick_i,
  input  wire logic        rc_osc_tick_i,
  input  wire logic        wdt_osc_tick_i,
  input  wire logic        lf_xtal_tick_i,
  input  wire logic        xtal_tick_i,
  input  wire logic        wake_i,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             core_clk_en_o,
  output logic             periph_clk_en_o,
  output logic             flash_clk_en_o,
  output logic             adc_clk_en_o,
  output logic             exec_run_o,
  output logic [2:0]       xtal_range_o,
  output logic             xtal_osc_on_o
);
  typedef enum logic [1:0] {ST_COUNT, ST_RUN, ST_SLEEP} clkss_state_e;

  clkss_state_e                        state_q;
  logic [clkss_pkg::FUSE_W-1:0]        fuse_q;
  logic [clkss_pkg::FUSE_W-1:0]        fuse_act_q;
  logic [1:0]                          pwr_mode_q;
  logic [1:0]                          slp_mode_q;
  logic                                start_q;
  logic                                from_reset_q;
  logic [clkss_pkg::DIV_W-1:0]         div_q;
  logic                                aw_hold_q;
  logic                                w_hold_q;
  logic [11:0]                         awaddr_q;
  logic [31:0]                         wdata_q;
  logic                                wstrb0_q;

  clkss_startup_if st_if ();

  clkss_startup_cnt u_cnt (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .st        (st_if)
  );

  // fuse decode on the copy caught at the last start
  wire logic [3:0] src_fuses = fuse_act_q[clkss_pkg::SEL_LSB +: 4];
  wire logic [1:0] su_fuses  = fuse_act_q[clkss_pkg::STARTUP_LSB +: 2];
  wire logic       div8_off  = fuse_act_q[clkss_pkg::DIV8_BIT];
  wire logic       is_xtal   = src_fuses[clkss_pkg::SEL_XTAL_BIT];
  wire logic       is_ext    = (src_fuses == clkss_pkg::SEL_EXT);
  wire logic       is_wdt    = (src_fuses == clkss_pkg::SEL_WDT);
  wire logic       is_lf     = (src_fuses == clkss_pkg::SEL_LF);
  wire logic       grp       = src_fuses[0];
  wire logic [2:0] xkey      = {grp, su_fuses};

  // selected source; reserved codes fall back to the internal RC so the part still boots
  wire logic src_tick = is_xtal ? xtal_tick_i    :
                        is_ext  ? ext_clk_tick_i :
                        is_wdt  ? wdt_osc_tick_i :
                        is_lf   ? lf_xtal_tick_i : rc_osc_tick_i;

  // crystal start-up counts by group bit and start-up fuses
  wire clkss_pkg::clkss_cnt_t xtal_su =
    (!grp && !su_fuses[1])       ? clkss_pkg::clkss_cnt_t'(clkss_pkg::XTAL_SHORT) :
    (!grp || su_fuses == 2'h0)   ? clkss_pkg::clkss_cnt_t'(clkss_pkg::XTAL_MID)   :
                                   clkss_pkg::clkss_cnt_t'(XTAL_LONG_CYC);
  wire clkss_pkg::clkss_cnt_t su_cyc =
    is_xtal ? xtal_su : clkss_pkg::clkss_cnt_t'(clkss_pkg::GEN_START);

  // reset delay kind: short is 4 ms class, long is 64 ms class
  wire logic dly_short = is_xtal ? (xkey == 3'h0 || xkey == 3'h3 || xkey == 3'h6)
                                 : (su_fuses == 2'h1);
  wire logic dly_long  = is_xtal ? (xkey == 3'h1 || xkey == 3'h4 || xkey == 3'h7)
                                 : su_fuses[1];

  // source count plus fourteen after reset; watchdog time only after reset
  assign st_if.src_cycles = from_reset_q
    ? clkss_pkg::clkss_cnt_t'(su_cyc + clkss_pkg::clkss_cnt_t'(clkss_pkg::RST_EXTRA)) : su_cyc;
  assign st_if.wdt_cycles = !from_reset_q ? '0 :
                            dly_long  ? clkss_pkg::clkss_cnt_t'(WDT_LONG_CYC) :
                            dly_short ? clkss_pkg::clkss_cnt_t'(clkss_pkg::WDT_SHORT_CYC) : '0;
  assign st_if.start    = start_q;
  assign st_if.src_tick = src_tick;
  assign st_if.wdt_tick = wdt_osc_tick_i;

  // clock generator: prescale by eight while that fuse is programmed
  wire logic sys_tick  = src_tick && (div8_off || div_q == '1);
  wire logic run       = (state_q == ST_RUN);
  wire logic asleep    = (state_q == ST_SLEEP);
  wire logic slp_deep  = (slp_mode_q == clkss_pkg::SLP_PWR_DOWN) || (slp_mode_q == clkss_pkg::SLP_PWR_SAVE);
  wire logic slp_idle  = (slp_mode_q == clkss_pkg::SLP_IDLE);
  wire logic slp_adc   = (slp_mode_q == clkss_pkg::SLP_ADC_NR);
  wire logic core_d    = sys_tick && run;
  wire logic periph_d  = sys_tick && (run || (asleep && slp_idle));
  wire logic adc_d     = sys_tick && (run || (asleep && (slp_idle || slp_adc)));
  wire logic osc_on_d  = is_xtal && !(asleep && slp_deep);

  // register bus decode
  wire logic [11:0] waddr_w  = {awaddr_q[11:2], 2'h0};
  wire logic [11:0] raddr_w  = {s_axi_araddr[11:2], 2'h0};
  wire logic        wr_fire  = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire logic        wsel_fu  = (waddr_w == clkss_pkg::REG_FUSE);
  wire logic        wsel_pw  = (waddr_w == clkss_pkg::REG_PWR);
  wire logic        wsel_ok  = wsel_fu || wsel_pw || (waddr_w == clkss_pkg::REG_STAT);
  wire logic        enter_w  = wr_fire && wsel_pw && wstrb0_q && wdata_q[clkss_pkg::PWR_ENTER_BIT];
  wire logic        rd_fire  = s_axi_arvalid && s_axi_arready;
  wire logic        rsel_ok  = (raddr_w == clkss_pkg::REG_FUSE) || (raddr_w == clkss_pkg::REG_PWR) ||
                               (raddr_w == clkss_pkg::REG_STAT);
  wire logic [31:0] stat_w   = (32'(fuse_act_q) << clkss_pkg::STAT_ACT_LSB) |
                               (32'(state_q) << clkss_pkg::STAT_ST_LSB) |
                               (32'(run) << clkss_pkg::STAT_RUN_BIT);
  wire logic [31:0] rdata_w  = (raddr_w == clkss_pkg::REG_FUSE) ? 32'(fuse_q) :
                               (raddr_w == clkss_pkg::REG_PWR)  ? 32'(pwr_mode_q) :
                               (raddr_w == clkss_pkg::REG_STAT) ? stat_w : 32'h0000_0000;

  // start-up sequencer; the wake pin needs no running clock to be seen
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q      <= ST_COUNT;
      start_q      <= 1'b1;
      from_reset_q <= 1'b1;
      fuse_act_q   <= clkss_pkg::FUSE_RST;
      slp_mode_q   <= clkss_pkg::SLP_IDLE;
    end else begin
      start_q <= 1'b0;
      unique case (state_q)
        ST_COUNT: begin
          if (!start_q && st_if.done) state_q <= ST_RUN;
        end
        ST_RUN: begin
          if (enter_w) begin
            state_q    <= ST_SLEEP;
            slp_mode_q <= wdata_q[clkss_pkg::PWR_MODE_LSB +: 2];
          end
        end
        ST_SLEEP: begin
          if (wake_i && slp_deep) begin
            state_q      <= ST_COUNT;
            start_q      <= 1'b1;
            from_reset_q <= 1'b0;
            fuse_act_q   <= fuse_q;
          end else if (wake_i) begin
            state_q <= ST_RUN;
          end
        end
      endcase
    end
  end

  // prescaler counts every source edge, gated or not
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) div_q <= '0;
    else if (src_tick) div_q <= div_q + 1'b1;
  end

  // registered domain enables and oscillator controls
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_clk_en_o   <= 1'b0;
      periph_clk_en_o <= 1'b0;
      flash_clk_en_o  <= 1'b0;
      adc_clk_en_o    <= 1'b0;
      exec_run_o      <= 1'b0;
      xtal_range_o    <= 3'h0;
      xtal_osc_on_o   <= 1'b0;
    end else begin
      core_clk_en_o   <= core_d;
      flash_clk_en_o  <= core_d;
      periph_clk_en_o <= periph_d;
      adc_clk_en_o    <= adc_d;
      exec_run_o      <= run;
      xtal_range_o    <= is_xtal ? src_fuses[3:1] : 3'h0;
      xtal_osc_on_o   <= osc_on_d;
    end
  end

  // write side: address and data taken in either order, one write in flight
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= 32'h0000_0000;
      wstrb0_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= clkss_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb0_q     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wsel_ok ? clkss_pkg::RESP_OKAY : clkss_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // software fuse image and sleep mode; fuses act only at the next wake from power-down or power-save
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fuse_q     <= clkss_pkg::FUSE_RST;
      pwr_mode_q <= clkss_pkg::SLP_IDLE;
    end else if (wr_fire && wstrb0_q) begin
      if (wsel_fu) fuse_q <= wdata_q[clkss_pkg::FUSE_W-1:0];
      if (wsel_pw) pwr_mode_q <= wdata_q[clkss_pkg::PWR_MODE_LSB +: 2];
    end
  end

  // read side: answer one cycle after the address is taken
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= clkss_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdata_w;
      s_axi_rresp   <= rsel_ok ? clkss_pkg::RESP_OKAY : clkss_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  property p_core_needs_run;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    core_clk_en_o |-> $past(state_q) == ST_RUN;
  endproperty
  a_core_needs_run: assert property (p_core_needs_run) else $error("core clock while not running");

  property p_flash_with_core;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    flash_clk_en_o == core_clk_en_o;
  endproperty
  a_flash_with_core: assert property (p_flash_with_core) else $error("flash clock split from core");

  property p_adc_quiet_sleep;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (asleep && slp_adc && sys_tick) |=> (adc_clk_en_o && !periph_clk_en_o && !core_clk_en_o);
  endproperty
  a_adc_quiet_sleep: assert property (p_adc_quiet_sleep) else $error("converter sleep gating wrong");

  property p_deep_all_off;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (asleep && slp_deep) |=> !(periph_clk_en_o || adc_clk_en_o || flash_clk_en_o);
  endproperty
  a_deep_all_off: assert property (p_deep_all_off) else $error("clock ran in deep sleep");

  property p_release_after_done;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(exec_run_o) |-> ($past(st_if.done, 2) && $past(state_q, 2) == ST_COUNT) ||
                          ($past(state_q, 2) == ST_SLEEP && !$past(slp_deep, 2));
  endproperty
  a_release_after_done: assert property (p_release_after_done) else $error("execution released early");

  property p_deep_wake_counts;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (asleep && slp_deep && wake_i) |=> (start_q && !from_reset_q && state_q == ST_COUNT) ##1 !run [*2];
  endproperty
  a_deep_wake_counts: assert property (p_deep_wake_counts) else $error("wake skipped start-up count");

  property p_reset_wdt_short;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (start_q && from_reset_q && dly_short && !dly_long) |-> st_if.wdt_cycles == 15'd512;
  endproperty
  a_reset_wdt_short: assert property (p_reset_wdt_short) else $error("short reset delay count wrong");

  // the shipped image always takes the long path, so this one is reached from every reset
  property p_reset_wdt_long;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (start_q && from_reset_q && dly_long) |-> st_if.wdt_cycles == clkss_pkg::clkss_cnt_t'(WDT_LONG_CYC);
  endproperty
  a_reset_wdt_long: assert property (p_reset_wdt_long) else $error("long reset delay count wrong");

  property p_xtal_258;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (start_q && is_xtal && !grp && !su_fuses[1]) |-> st_if.src_cycles == (from_reset_q ? 15'd272 : 15'd258);
  endproperty
  a_xtal_258: assert property (p_xtal_258) else $error("short crystal start-up count wrong");

  property p_xtal_range;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    is_xtal |=> xtal_range_o == $past(src_fuses[3:1]);
  endproperty
  a_xtal_range: assert property (p_xtal_range) else $error("crystal range not from select bits");
endmodule

/* File: verification/clkss_osc_model.sv */
// oscillator sources feeding the clock select block, one tick per edge
// assumes ticks are sampled on the rising edge of clk_sys_i
`timescale 1ns/10ps
module clkss_osc_model (
  input  wire logic clk_sys_i,
  output logic      ext_o,
  output logic      rc_o,
  output logic      wdt_o,
  output logic      lf_o,
  output logic      xtal_o
);
  int unsigned c = 0;
  initial {ext_o, rc_o, wdt_o, lf_o, xtal_o} = 5'h00;
  // crystal stand-in is a ceramic resonator, so range 100 and 258-cycle starts are legal
  // offset phases keep the ext, RC and crystal ticks apart; watchdog and LF ticks can land on the same cycle as them
  always @(posedge clk_sys_i) begin
    c      <= c + 1;
    ext_o  <= (c % 3) == 0;
    rc_o   <= (c % 3) == 1;
    wdt_o  <= (c % 4) == 2;
    lf_o   <= (c % 5) == 3;
    xtal_o <= (c % 3) == 2;
  end
endmodule

/* File: verification/clkss_top_test.sv */
// self-checking bench for the clock source select and start-up block
// assumes the oscillator model supplies every source tick
`timescale 1ns/10ps
module clkss_top_test;
  localparam int XL = 40;
  localparam int WL = 30;
  typedef struct {logic [6:0] f; logic [2:0] rg; int n;} clkss_row_s;
  logic        clk_sys_i = 1'b0, resetn_i = 1'b0, wake_i = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'h0, cur_sel = 4'h2;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, stk;
  logic        t_ext, t_rc, t_wdt, t_lf, t_xt, core_en, per_en, fl_en, adc_en, run, xon;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  rng;
  int          n_errors = 0, tests_run = 0, cyc = 0, n, g;
  // wake counts: no 14 extra and no watchdog part after power-down
  clkss_row_s  rows[10] = '{'{7'h40, 3'h0, 6}, '{7'h44, 3'h0, 6}, '{7'h46, 3'h0, 6},
                           '{7'h49, 3'h4, 1024}, '{7'h5A, 3'h5, 258}, '{7'h6C, 3'h6, 1024},
                           '{7'h7F, 3'h7, XL}, '{7'h5B, 3'h5, XL}, '{7'h43, 3'h0, 6}, '{7'h42, 3'h0, 6}};
  // tick of the source the current fuse image selects; reserved codes fall back to RC
  assign stk = cur_sel[3] ? t_xt : (cur_sel == 4'h0) ? t_ext : (cur_sel == 4'h4) ? t_wdt :
               (cur_sel == 4'h6) ? t_lf : t_rc;
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  clkss_osc_model u_osc (.clk_sys_i(clk_sys_i), .ext_o(t_ext), .rc_o(t_rc), .wdt_o(t_wdt),
                         .lf_o(t_lf), .xtal_o(t_xt));
  clkss_top #(.XTAL_LONG_CYC(XL), .WDT_LONG_CYC(WL)) u_dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ext_clk_tick_i(t_ext), .rc_osc_tick_i(t_rc),
    .wdt_osc_tick_i(t_wdt), .lf_xtal_tick_i(t_lf), .xtal_tick_i(t_xt), .wake_i(wake_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .core_clk_en_o(core_en), .periph_clk_en_o(per_en),
    .flash_clk_en_o(fl_en), .adc_clk_en_o(adc_en), .exec_run_o(run), .xtal_range_o(rng),
    .xtal_osc_on_o(xon));

  task finish_test;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [63:0] s, input logic [63:0] e, input string m);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %0t %s seen %h want %h", $time, m, s, e);
    end
  endtask
  // write: address and data offered together, bready held until the answer
  task wr(input logic [11:0] a, input logic [31:0] v);
    g = 0; awaddr <= a; wdata <= v; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk_sys_i); g++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && g < 50);
    r = bresp; bready <= 1'b0; chk(g < 50, 1, "write hang");
    @(posedge clk_sys_i);
  endtask
  task rd(input logic [11:0] a);
    g = 0; araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk_sys_i); g++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && g < 50);
    d = rdata; r = rresp; rready <= 1'b0; chk(g < 50, 1, "read hang");
    @(posedge clk_sys_i);
  endtask
  task do_reset;
    resetn_i <= 1'b0; cur_sel = 4'h2;
    repeat (5) @(posedge clk_sys_i);
    chk({core_en, per_en, fl_en, adc_en, run, rng, xon}, 0, "outputs in reset");
    chk({awready, wready, arready, bvalid, rvalid}, 5'b11100, "bus in reset");
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
  endtask
  // each enable pulse follows the selected tick by one cycle; flash mirrors core
  task en_window(input int c);
    logic p;
    @(posedge clk_sys_i); p = stk;
    repeat (c) begin
      @(posedge clk_sys_i);
      chk(core_en, p, "core enable vs tick");
      chk(fl_en, core_en, "flash enable");
      p = stk;
    end
  endtask
  // light sleep: which domains keep ticking, then immediate wake
  task sleep_win(input logic [31:0] mode, input logic pe, input logic ae);
    int nc, np, na;
    nc = 0; np = 0; na = 0;
    wr(clkss_pkg::REG_PWR, mode | 32'h4);
    repeat (30) begin
      @(posedge clk_sys_i); nc += core_en; np += per_en; na += adc_en;
    end
    chk(nc, 0, "core halted");
    chk(np > 0, pe, "peripheral clock");
    chk(na > 0, ae, "converter clock");
    wake_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk(run, 1, "light wake");
    wake_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // ceiling well above the longest wake sequence
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      finish_test;
    end
  end

  initial begin
    do_reset;
    // start from shipped image: long delay, cut to WL watchdog ticks here
    n = 0; g = 0;
    while (run !== 1'b1 && g < 2000) begin
      @(posedge clk_sys_i); g++; n += t_wdt;
      chk(core_en, 0, "core gated in start-up");
    end
    chk(n >= WL && n <= WL + 2, 1, "reset delay");
    rd(clkss_pkg::REG_FUSE);
    chk({r, d}, {clkss_pkg::RESP_OKAY, 32'h22}, "shipped fuses");
    n = 0;
    repeat (240) begin
      @(posedge clk_sys_i); n += core_en;
    end
    chk(n >= 9 && n <= 11, 1, "divide by eight");
    foreach (rows[i]) begin
      wr(clkss_pkg::REG_FUSE, {25'h0, rows[i].f});
      wr(clkss_pkg::REG_PWR, 32'h6);
      cur_sel = rows[i].f[3:0];
      repeat (6) begin
        @(posedge clk_sys_i);
        chk({run, core_en, per_en, fl_en, adc_en, xon}, 0, "power-down halts");
      end
      wake_i <= 1'b1; n = 0; g = 0;
      while (run !== 1'b1 && g < 5000) begin
        @(posedge clk_sys_i); g++; n += stk;
      end
      wake_i <= 1'b0;
      chk(n >= rows[i].n && n <= rows[i].n + 2, 1, "wake count");
      chk(rng, rows[i].rg, "crystal range");
      chk(xon, rows[i].f[3], "amplifier on");
      en_window(30);
    end
    sleep_win(32'h0, 1'b1, 1'b1);
    sleep_win(32'h1, 1'b0, 1'b1);
    rd(12'h00C);
    chk({r, d}, {clkss_pkg::RESP_SLVERR, 32'h0}, "unmapped read");
    wr(clkss_pkg::REG_STAT, 32'hFFFFFFFF);
    chk(r, clkss_pkg::RESP_OKAY, "status write");
    rd(clkss_pkg::REG_PWR);
    chk(d, 32'h1, "power reg");
    rd(clkss_pkg::REG_STAT);
    chk({d[12], d[9:8], d[6:0]}, {1'b1, 2'h1, 7'h42}, "status");
    // reset in mid-run restores the shipped image
    do_reset;
    rd(clkss_pkg::REG_FUSE);
    chk(d, 32'h22, "fuses after reset");
    finish_test;
  end
endmodule
